// ### design/core_status_stack_pointers.sv
// Behaviour
// [RULE1] Return stack stores sixteen return addresses of fifteen bits each.
// [RULE2] Push when full or pop when empty sets a flag; optional soft reset.
// [RULE3] Two independent sixteen-bit pointers reach data and program memory.
// [RULE4] Indirect access to program memory costs one extra cycle.
// [RULE5] Pointers give a linear view of general purpose memory.
// [RULE6] Interrupt entry saves core registers to shadows; return restores them.
// [RULE7] Flag-updating instruction aimed at status keeps flag logic, drops the write.
// [RULE8] Watchdog-expiry and sleep-entered bits ignore instruction writes.
// [RULE9] Clear-file on status zeroes top bits, sets zero, keeps the rest.
// [RULE10] Software should alter status only with non-flag-changing instructions.
// [RULE11] Subtraction carry and digit carry are active-low borrows.
// [RULE12] Status bits seven to five are unimplemented and read zero.
// [RULE13] Power-on reset sets expiry and sleep bits, clears arithmetic flags.
// [RULE14] Decoder accepts exactly forty-nine instruction codes.
// [RULE15] Expiry bit set by power-up, kick or sleep; cleared by watchdog time-out.
// [RULE16] Sleep bit set by power-up or kick; cleared by sleep instruction.
// [RULE17] Digit carry from bit three, carry from most significant bit.
// [RULE18] Rotates load carry from the low or high source bit.
module core_status_stack_pointers
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        other_reset,
  input  wire logic        wdt_timeout,
  input  wire logic        instr_valid,
  input  wire logic [5:0]  instr_op,
  input  wire logic [7:0]  operand_a,
  input  wire logic [7:0]  operand_b,
  input  wire logic        dest_status,
  input  wire logic        ptr_sel,
  input  wire logic [2:0]  bit_sel,
  input  wire logic [14:0] pc_in,
  input  wire logic        irq_entry,
  input  wire logic [7:0]  w_in,
  input  wire logic [4:0]  bsr_in,
  input  wire logic [6:0]  pclath_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  status_out,
  output logic      [7:0]  result,
  output logic             result_valid,
  output logic      [14:0] ret_addr,
  output logic             ret_valid,
  output logic      [15:0] ind_addr,
  output logic             ind_prog,
  output logic             ind_valid,
  output logic             ind_wait,
  output logic             restore_valid,
  output logic      [7:0]  w_restore,
  output logic      [4:0]  bsr_restore,
  output logic      [6:0]  pclath_restore,
  output logic             soft_reset,
  output logic             irq
);
  import core_pkg::*;

  stack_if stk ();

  logic [7:0]      status;
  logic [7:0]      next_status;
  logic [2:0]      power_reset_cause_reg;
  logic [15:0]     ptr0;
  logic [15:0]     ptr1;
  logic [15:0]     next_ptr0;
  logic [15:0]     next_ptr1;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [7:0]      sh_status;
  logic [15:0]     sh_ptr0;
  logic [15:0]     sh_ptr1;
  ind_state_e      ind_state;
  logic            op_ok;
  logic            is_op_ind;
  logic [7:0]      alu_res;
  logic [2:0]      aff;
  logic [2:0]      flg;
  logic            wr_file;
  logic [8:0]      sum;
  logic [4:0]      nib;
  logic [15:0]     sel_ptr;
  logic [15:0]     lin_off;
  logic [15:0]     phys;
  logic            apb_do;
  logic            apb_wr;
  logic            apb_rd;
  logic            hit;
  logic [31:0]     rdata;

  return_stack u_stack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .stk     (stk.store)
  );

  // ==========================================================
  // Decode and arithmetic
  assign op_ok     = instr_valid && (instr_op < INSTR_COUNT); // [RULE14]
  assign is_op_ind = op_ok && (instr_op == OP_MOVIW || instr_op == OP_MOVWI);

  always_comb begin
    alu_res = operand_a;
    aff     = 3'b000;
    flg     = status[2:0];
    wr_file = 1'b0;
    sum     = 9'h000;
    nib     = 5'h00;
    case (instr_op)
      OP_ADD: begin
        sum        = {1'b0, operand_a} + {1'b0, operand_b};
        nib        = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]};
        alu_res    = sum[7:0];
        aff        = 3'b111;
        flg[BIT_C]  = sum[8]; // [RULE17]
        flg[BIT_DC] = nib[4]; // [RULE17]
        wr_file    = 1'b1;
      end
      OP_SUB: begin
        sum        = {1'b0, operand_a} + {1'b0, ~operand_b} + 9'h001;
        nib        = {1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]} + 5'h01;
        alu_res    = sum[7:0];
        aff        = 3'b111;
        flg[BIT_C]  = sum[8]; // [RULE11]
        flg[BIT_DC] = nib[4]; // [RULE11]
        wr_file    = 1'b1;
      end
      OP_AND: begin
        alu_res = operand_a & operand_b;
        aff     = 3'b100;
        wr_file = 1'b1;
      end
      OP_IOR: begin
        alu_res = operand_a | operand_b;
        aff     = 3'b100;
        wr_file = 1'b1;
      end
      OP_RRF: begin
        alu_res    = {status[BIT_C], operand_a[7:1]};
        flg[BIT_C] = operand_a[0]; // [RULE18]
        aff        = 3'b001;
        wr_file    = 1'b1;
      end
      OP_RLF: begin
        alu_res    = {operand_a[6:0], status[BIT_C]};
        flg[BIT_C] = operand_a[7]; // [RULE18]
        aff        = 3'b001;
        wr_file    = 1'b1;
      end
      OP_CLEAR_FILE_INSTR: begin
        alu_res = 8'h00;
        aff     = 3'b100; // [RULE9]
        wr_file = 1'b1;
      end
      OP_BCF: begin
        alu_res = operand_a & ~(8'h01 << bit_sel);
        wr_file = 1'b1;
      end
      OP_BSF: begin
        alu_res = operand_a | (8'h01 << bit_sel);
        wr_file = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_INSTR: begin
        alu_res = {operand_a[3:0], operand_a[7:4]};
        wr_file = 1'b1;
      end
      OP_MOVE_W_TO_FILE_INSTR: begin
        alu_res = operand_b;
        wr_file = 1'b1;
      end
      default: begin
      end
    endcase
    if (aff[BIT_Z]) begin
      flg[BIT_Z] = (alu_res == 8'h00);
    end
  end

  // ==========================================================
  // Status register
  always_comb begin
    next_status = status;
    if (op_ok) begin
      if (dest_status && wr_file && aff == 3'b000) begin
        next_status[2:0] = alu_res[2:0]; // [RULE8]
      end
      for (int i = 0; i < 3; i++) begin
        if (aff[i]) begin
          next_status[i] = flg[i]; // [RULE7]
        end
      end
      if (instr_op == OP_RETFIE) begin
        next_status[2:0] = sh_status[2:0]; // [RULE6]
      end
      if (instr_op == OP_WATCHDOG_KICK_INSTR) begin
        next_status[BIT_TO] = 1'b1; // [RULE15]
        next_status[BIT_PD] = 1'b1; // [RULE16]
      end
      if (instr_op == OP_SLEEP) begin
        next_status[BIT_TO] = 1'b1; // [RULE15]
        next_status[BIT_PD] = 1'b0; // [RULE16]
      end
    end else if (apb_wr && paddr == REG_STATUS) begin
      next_status[2:0] = pwdata[2:0];
    end
    if (wdt_timeout) begin
      next_status[BIT_TO] = 1'b0; // [RULE15]
    end
    next_status[7:5] = 3'b000; // [RULE12]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= STATUS_RESET; // [RULE13]
    end else if (clk_en) begin
      status <= next_status; // [RULE13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result       <= 8'h00;
      result_valid <= 1'b0;
      status_out   <= STATUS_RESET;
    end else if (clk_en) begin
      result       <= alu_res;
      result_valid <= op_ok && wr_file;
      status_out   <= next_status;
    end
  end

  // ==========================================================
  // Indirect pointers
  always_comb begin
    next_ptr0 = ptr0;
    next_ptr1 = ptr1;
    if (op_ok && instr_op == OP_RETFIE) begin
      next_ptr0 = sh_ptr0; // [RULE6]
      next_ptr1 = sh_ptr1;
    end else if (op_ok && instr_op == OP_ADDFSR) begin
      if (ptr_sel) begin
        next_ptr1 = ptr1 + {{10{operand_b[5]}}, operand_b[5:0]}; // [RULE3]
      end else begin
        next_ptr0 = ptr0 + {{10{operand_b[5]}}, operand_b[5:0]}; // [RULE3]
      end
    end else if (apb_wr && paddr == REG_PTR0) begin
      next_ptr0 = pwdata[15:0];
    end else if (apb_wr && paddr == REG_PTR1) begin
      next_ptr1 = pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr0 <= 16'h0000;
      ptr1 <= 16'h0000;
    end else if (clk_en) begin
      ptr0 <= next_ptr0;
      ptr1 <= next_ptr1;
    end
  end

  always_comb begin
    sel_ptr = ptr_sel ? ptr1 : ptr0;
    lin_off = sel_ptr - LIN_BASE;
    if (sel_ptr[PROG_BIT]) begin
      phys = {1'b0, sel_ptr[14:0]}; // [RULE3]
    end else if (sel_ptr >= LIN_BASE && sel_ptr <= LIN_END) begin
      phys = 16'((lin_off / LIN_BANK_SIZE) * BANK_STRIDE) + GP_OFFSET
             + (lin_off % LIN_BANK_SIZE); // [RULE5]
    end else begin
      phys = sel_ptr & TRAD_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ind_state <= IND_IDLE;
      ind_addr  <= 16'h0000;
      ind_prog  <= 1'b0;
      ind_valid <= 1'b0;
      ind_wait  <= 1'b0;
    end else if (clk_en) begin
      ind_valid <= 1'b0;
      case (ind_state)
        IND_IDLE: begin
          if (is_op_ind) begin
            ind_addr <= phys;
            ind_prog <= sel_ptr[PROG_BIT];
            if (sel_ptr[PROG_BIT]) begin
              ind_wait  <= 1'b1; // [RULE4]
              ind_state <= IND_FETCH;
            end else begin
              ind_valid <= 1'b1;
            end
          end
        end
        IND_FETCH: begin
          ind_wait  <= 1'b0;
          ind_valid <= 1'b1; // [RULE4]
          ind_state <= IND_IDLE;
        end
        default: begin
          ind_state <= IND_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Return stack control and shadows
  assign stk.push      = irq_entry || (op_ok && instr_op == OP_CALL);
  assign stk.pop       = !irq_entry && op_ok &&
                         (instr_op == OP_RETURN || instr_op == OP_RETFIE);
  assign stk.clear     = other_reset;
  assign stk.push_addr = pc_in;
  assign ret_addr      = stk.pop_addr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sh_status      <= 8'h00;
      sh_ptr0        <= 16'h0000;
      sh_ptr1        <= 16'h0000;
      w_restore      <= 8'h00;
      bsr_restore    <= 5'h00;
      pclath_restore <= 7'h00;
      restore_valid  <= 1'b0;
      ret_valid      <= 1'b0;
    end else if (clk_en) begin
      ret_valid     <= stk.pop;
      restore_valid <= stk.pop && instr_op == OP_RETFIE; // [RULE6]
      if (irq_entry) begin
        sh_status      <= status; // [RULE6]
        sh_ptr0        <= ptr0;
        sh_ptr1        <= ptr1;
        w_restore      <= w_in;
        bsr_restore    <= bsr_in;
        pclath_restore <= pclath_in;
      end
    end
  end

  // ==========================================================
  // Reset cause flags and events
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_reset_cause_reg       <= 3'b000;
      soft_reset <= 1'b0;
    end else if (clk_en) begin
      if (apb_wr && paddr == REG_POWER_RESET_CAUSE_REG) begin
        power_reset_cause_reg[POWER_RESET_CAUSE_REG_RST_EN] <= pwdata[POWER_RESET_CAUSE_REG_RST_EN];
        power_reset_cause_reg[POWER_RESET_CAUSE_REG_OVF]    <= pwdata[POWER_RESET_CAUSE_REG_OVF] || stk.overflow; // [RULE2]
        power_reset_cause_reg[POWER_RESET_CAUSE_REG_UNF]    <= pwdata[POWER_RESET_CAUSE_REG_UNF] || stk.underflow; // [RULE2]
      end else begin
        power_reset_cause_reg[POWER_RESET_CAUSE_REG_OVF] <= power_reset_cause_reg[POWER_RESET_CAUSE_REG_OVF] || stk.overflow; // [RULE2]
        power_reset_cause_reg[POWER_RESET_CAUSE_REG_UNF] <= power_reset_cause_reg[POWER_RESET_CAUSE_REG_UNF] || stk.underflow; // [RULE2]
      end
      soft_reset <= power_reset_cause_reg[POWER_RESET_CAUSE_REG_RST_EN] && (stk.overflow || stk.underflow); // [RULE2]
    end
  end

  always_comb begin
    ev_set             = '0;
    ev_set[EV_OVF]     = stk.overflow;
    ev_set[EV_UNF]     = stk.underflow;
    ev_set[EV_WDT]     = wdt_timeout;
    ev_set[EV_ILLEGAL] = instr_valid && !op_ok; // [RULE14]
    ev_clr             = (apb_rd && paddr == REG_EVENT) ? prdata[EV_W-1:0] : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      events <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end else if (clk_en) begin
      events <= (events & ~ev_clr) | ev_set;
      if (apb_wr && paddr == REG_MASK) begin
        mask <= pwdata[EV_W-1:0];
      end
      irq <= |(events & mask);
    end
  end

  // ==========================================================
  // APB slave
  assign apb_do = psel && penable && pready;
  assign apb_wr = apb_do && pwrite && !pslverr;
  assign apb_rd = apb_do && !pwrite && !pslverr;

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      REG_STATUS: rdata[7:0]      = status;
      REG_POWER_RESET_CAUSE_REG:   rdata[2:0]      = power_reset_cause_reg;
      REG_PTR0:   rdata[15:0]     = ptr0;
      REG_PTR1:   rdata[15:0]     = ptr1;
      REG_EVENT:  rdata[EV_W-1:0] = events;
      REG_MASK:   rdata[EV_W-1:0] = mask;
      REG_DEPTH:  rdata[4:0]      = stk.depth;
      default:    hit             = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !hit;
        prdata  <= hit ? rdata : 32'h0000_0000;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // core_status_stack_pointers

// ### design/core_pkg.sv
package core_pkg;
  // ==========================================================
  // Status register layout
  localparam int          BIT_C         = 0;
  localparam int          BIT_DC        = 1;
  localparam int          BIT_Z         = 2;
  localparam int          BIT_PD        = 3;
  localparam int          BIT_TO        = 4;
  localparam logic [7:0]  STATUS_RESET  = 8'h18;
  // ==========================================================
  // Return stack
  localparam int          STACK_DEPTH   = 16;
  localparam int          ADDR_W        = 15;
  localparam logic [4:0]  STACK_FULL    = 5'h10;
  // ==========================================================
  // Instruction codes
  localparam logic [5:0]  INSTR_COUNT   = 6'h31;
  localparam logic [5:0]  OP_ADD        = 6'h00;
  localparam logic [5:0]  OP_SUB        = 6'h01;
  localparam logic [5:0]  OP_AND        = 6'h02;
  localparam logic [5:0]  OP_IOR        = 6'h03;
  localparam logic [5:0]  OP_RRF        = 6'h04;
  localparam logic [5:0]  OP_RLF        = 6'h05;
  localparam logic [5:0]  OP_CLEAR_FILE_INSTR       = 6'h06;
  localparam logic [5:0]  OP_BCF        = 6'h07;
  localparam logic [5:0]  OP_BSF        = 6'h08;
  localparam logic [5:0]  OP_NIBBLE_EXCHANGE_INSTR      = 6'h09;
  localparam logic [5:0]  OP_MOVE_W_TO_FILE_INSTR      = 6'h0a;
  localparam logic [5:0]  OP_WATCHDOG_KICK_INSTR     = 6'h0b;
  localparam logic [5:0]  OP_SLEEP      = 6'h0c;
  localparam logic [5:0]  OP_CALL       = 6'h0d;
  localparam logic [5:0]  OP_RETURN     = 6'h0e;
  localparam logic [5:0]  OP_RETFIE     = 6'h0f;
  localparam logic [5:0]  OP_MOVIW      = 6'h10;
  localparam logic [5:0]  OP_MOVWI      = 6'h11;
  localparam logic [5:0]  OP_ADDFSR     = 6'h12;
  // ==========================================================
  // Pointer space
  localparam logic [15:0] LIN_BASE      = 16'h2000;
  localparam logic [15:0] LIN_END       = 16'h29af;
  localparam logic [15:0] LIN_BANK_SIZE = 16'h0050;
  localparam logic [15:0] BANK_STRIDE   = 16'h0080;
  localparam logic [15:0] GP_OFFSET     = 16'h0020;
  localparam logic [15:0] TRAD_MASK     = 16'h0fff;
  localparam int          PROG_BIT      = 15;
  // ==========================================================
  // Register map
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_POWER_RESET_CAUSE_REG      = 8'h04;
  localparam logic [7:0]  REG_PTR0      = 8'h08;
  localparam logic [7:0]  REG_PTR1      = 8'h0c;
  localparam logic [7:0]  REG_EVENT     = 8'h10;
  localparam logic [7:0]  REG_MASK      = 8'h14;
  localparam logic [7:0]  REG_DEPTH     = 8'h18;
  localparam int          POWER_RESET_CAUSE_REG_UNF      = 0;
  localparam int          POWER_RESET_CAUSE_REG_OVF      = 1;
  localparam int          POWER_RESET_CAUSE_REG_RST_EN   = 2;
  localparam int          EV_OVF        = 0;
  localparam int          EV_UNF        = 1;
  localparam int          EV_WDT        = 2;
  localparam int          EV_ILLEGAL    = 3;
  localparam int          EV_W          = 4;
  typedef enum logic {IND_IDLE, IND_FETCH} ind_state_e;
endpackage

// ### design/stack_if.sv
interface stack_if;
  logic        push;
  logic        pop;
  logic        clear;
  logic [14:0] push_addr;
  logic [14:0] pop_addr;
  logic [4:0]  depth;
  logic        overflow;
  logic        underflow;
  modport owner (output push, pop, clear, push_addr,
                 input  pop_addr, depth, overflow, underflow);
  modport store (input  push, pop, clear, push_addr,
                 output pop_addr, depth, overflow, underflow);
endinterface

// ### design/return_stack.sv
module return_stack
  import core_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  stack_if.store   stk
);
  logic [ADDR_W-1:0] mem [STACK_DEPTH];
  logic [4:0]        count;

  // ==========================================================
  // Storage and pointer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count         <= 5'h00;
      stk.pop_addr  <= 15'h0000;
      stk.overflow  <= 1'b0;
      stk.underflow <= 1'b0;
    end else if (clk_en) begin
      stk.overflow  <= 1'b0;
      stk.underflow <= 1'b0;
      if (stk.clear) begin
        count <= 5'h00;
      end else if (stk.push) begin
        if (count == STACK_FULL) begin
          stk.overflow <= 1'b1; // [RULE2]
        end else begin
          mem[count[3:0]] <= stk.push_addr; // [RULE1]
          count           <= count + 5'h01;
        end
      end else if (stk.pop) begin
        if (count == 5'h00) begin
          stk.underflow <= 1'b1; // [RULE2]
          stk.pop_addr  <= 15'h0000;
        end else begin
          stk.pop_addr <= mem[4'(count - 5'h01)];
          count        <= count - 5'h01;
        end
      end
    end
  end

  assign stk.depth = count;
endmodule // return_stack

// ### dv/csp_monitor.sv
// ==========
// Checker on the top ports
module csp_monitor
  import core_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       wdt_timeout,
  input wire logic       instr_valid,
  input wire logic [5:0] instr_op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic       dest_status,
  input wire logic       irq_entry,
  input wire logic [7:0] w_in,
  input wire logic [7:0] status_out,
  input wire logic       ind_wait,
  input wire logic       ind_valid,
  input wire logic       ind_prog,
  input wire logic       restore_valid,
  input wire logic [7:0] w_restore
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sub;
  logic       go;
  logic       rot_c;
  logic [7:0] bx;
  logic [8:0] sum;
  logic [4:0] lo;
  logic [2:0] flags;
  logic [7:0] w_saved;
  assign sub   = instr_op == OP_SUB;
  assign go    = instr_valid && clk_en && !wdt_timeout;
  assign bx    = sub ? ~operand_b : operand_b;
  assign sum   = 9'(operand_a) + 9'(bx) + 9'(sub);
  assign lo    = 5'(operand_a[3:0]) + 5'(bx[3:0]) + 5'(sub);
  assign flags = {sum[7:0] == 8'h00, lo[4], sum[8]};
  assign rot_c = (instr_op == OP_RRF) ? operand_a[0] : operand_a[7];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      w_saved <= 8'h00;
    end else if (irq_entry && clk_en) begin
      w_saved <= w_in;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  a_top_bits_zero: assert property (
    status_out[7:5] == 3'b000) else $error("status top bits set");
  a_arith_flags: assert property (
    go && dest_status && (sub || instr_op == OP_ADD) |=> status_out[2:0] == $past(flags))
    else $error("arithmetic flags wrong");
  a_rotate_carry: assert property (
    go && dest_status && (instr_op == OP_RRF || instr_op == OP_RLF)
    |=> status_out[0] == $past(rot_c)) else $error("rotate carry wrong");
  a_clear_status: assert property (
    go && dest_status && instr_op == OP_CLEAR_FILE_INSTR
    |=> status_out == (($past(status_out) & 8'h1b) | 8'h04)) else $error("clear status wrong");
  a_kick_sets_both: assert property (
    go && instr_op == OP_WATCHDOG_KICK_INSTR |=> status_out[4:3] == 2'b11) else $error("kick bits wrong");
  a_sleep_clears_pd: assert property (
    go && instr_op == OP_SLEEP |=> status_out[4:3] == 2'b10) else $error("sleep bits wrong");
  a_wdt_clears_to: assert property (
    wdt_timeout && clk_en |=> !status_out[4]) else $error("expiry bit not cleared");
  a_prog_extra_cycle: assert property (
    $rose(ind_wait) |-> !ind_valid ##1 (ind_valid && ind_prog)) else $error("fetch cycle wrong");
  a_shadow_restore: assert property (
    restore_valid |-> w_restore == w_saved) else $error("shadow value wrong");
  c_prog_fetch: cover property ($rose(ind_wait));
  c_restore: cover property (restore_valid);
  c_clear: cover property (go && dest_status && instr_op == OP_CLEAR_FILE_INSTR);
endmodule // csp_monitor

bind core_status_stack_pointers csp_monitor mon (.*);

// ### dv/test_core_status_stack_pointers.sv
module test_core_status_stack_pointers;
  timeunit 1ns;
  timeprecision 1ns;
  import core_pkg::*;
  logic        ref_clk, rst, clk_en, other_reset, wdt_timeout, instr_valid;
  logic        dest_status, ptr_sel, irq_entry, psel, penable, pwrite;
  logic        pready, pslverr, result_valid, ret_valid, ind_prog, ind_valid;
  logic        ind_wait, restore_valid, soft_reset, irq;
  logic [2:0]  bit_sel;
  logic [4:0]  bsr_in, bsr_restore;
  logic [5:0]  instr_op;
  logic [6:0]  pclath_in, pclath_restore;
  logic [7:0]  operand_a, operand_b, w_in, paddr, result, status_out, w_restore;
  logic [14:0] pc_in, ret_addr;
  logic [15:0] ind_addr;
  logic [31:0] pwdata, prdata;
  logic [33:0] q_rd[$];
  logic [14:0] q_ret[$];
  logic [15:0] q_ind[$];
  logic [19:0] q_res[$];
  logic [15:0] pv[5] = '{16'h2055, 16'h29af, 16'h29b0, 16'h0f7f, 16'h8123};
  logic [15:0] pa[5] = '{16'h00a5, 16'h0f6f, 16'h09b0, 16'h0f7f, 16'h0123};
  int          bad_count = 0;
  int          samples_checked = 0;
  int          soft_seen = 0;
  int          res_seen = 0;

  core_status_stack_pointers dut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ==========
  // Tasks
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic i = 0,
                    input logic e = 0);
    q_rd.push_back({i, e, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic ins(input logic [5:0] op, input logic [7:0] a = 0, input logic ds = 0,
                     input logic [7:0] b = 0);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_op    <= op;
    operand_a   <= a;
    operand_b   <= b;
    dest_status <= ds;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
  endtask
  task automatic ev(input logic [2:0] s);
    @(posedge ref_clk);
    {irq_entry, other_reset, wdt_timeout} <= s;
    @(posedge ref_clk);
    {irq_entry, other_reset, wdt_timeout} <= 3'b000;
  endtask
  task automatic conclude();
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========
  // Output watcher
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk({irq, pslverr, prdata}, q_rd.pop_front());
    if (ret_valid === 1'b1) chk(34'(ret_addr), 34'(q_ret.pop_front()));
    if (ind_valid === 1'b1) chk(34'({ind_prog, ind_addr[14:0]}), 34'(q_ind.pop_front()));
    if (restore_valid === 1'b1) chk(34'({w_restore, bsr_restore, pclath_restore}), 34'(q_res.pop_front()));
    if (soft_reset === 1'b1) soft_seen++;
    if (result_valid === 1'b1) res_seen++;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
  // ==========
  // Scenarios
  initial begin
    logic [7:0]  a, b;
    logic [2:0]  f;
    logic [14:0] r;
    {rst, clk_en, other_reset, wdt_timeout, instr_valid, dest_status, ptr_sel} = 7'h60;
    {irq_entry, psel, penable, pwrite, instr_op, operand_a, operand_b} = '0;
    {bit_sel, pc_in, w_in, bsr_in, pclath_in, paddr, pwdata} = '0;
    void'($urandom(81));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_STATUS, 32'h0000_0018);
    rd(8'h1c, 32'h0000_0000, 0, 1);
    pc_in <= 15'h1234;
    ins(OP_CALL);
    ins(OP_CALL);
    ev(3'b010);
    rd(REG_DEPTH, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_0007);
    rd(REG_STATUS, 32'h0000_001f);
    ins(OP_MOVE_W_TO_FILE_INSTR, 0, 1, 8'he0);
    rd(REG_STATUS, 32'h0000_0018);
    wr(REG_STATUS, 32'h0000_00fb);
    ins(OP_CLEAR_FILE_INSTR, 0, 1);
    rd(REG_STATUS, 32'h0000_001f);
    ins(OP_BCF, 8'h1f, 1);
    rd(REG_STATUS, 32'h0000_001e);
    for (int k = 0; k < 8; k++) begin
      a = 8'($urandom);
      b = (k == 7) ? a : 8'($urandom);
      f = k[0] ? {a == b, a[3:0] >= b[3:0], a >= b}
               : {8'(a + b) == 8'h00, a[3:0] + b[3:0] > 15, a + b > 255};
      ins(k[0] ? OP_SUB : OP_ADD, a, 1, b);
      rd(REG_STATUS, {24'h0, 5'h03, f});
      chk(34'(result), 34'(8'(k[0] ? a - b : a + b)));
    end
    wr(REG_STATUS, 32'h0000_0000);
    ins(OP_RRF, 8'h01, 1);
    rd(REG_STATUS, 32'h0000_0019);
    ins(OP_RLF, 8'h7f, 1);
    rd(REG_STATUS, 32'h0000_0018);
    wr(REG_MASK, 32'h0000_0004);
    ins(OP_SLEEP);
    rd(REG_STATUS, 32'h0000_0010);
    clk_en <= 1'b0;
    ev(3'b001);
    clk_en <= 1'b1;
    rd(REG_STATUS, 32'h0000_0010);
    ev(3'b001);
    rd(REG_STATUS, 32'h0000_0000, 1);
    rd(REG_EVENT, 32'h0000_0004, 1);
    rd(REG_EVENT, 32'h0000_0000);
    ins(OP_WATCHDOG_KICK_INSTR);
    rd(REG_STATUS, 32'h0000_0018);
    wr(REG_MASK, 32'h0000_0000);
    ev(3'b001);
    rd(REG_EVENT, 32'h0000_0004);
    ins(6'd48);
    ins(6'd49);
    rd(REG_EVENT, 32'h0000_0008);
    for (int i = 0; i < 5; i++) begin
      ptr_sel <= i[0];
      wr(i[0] ? REG_PTR1 : REG_PTR0, {16'h0, pv[i]});
      q_ind.push_back({i == 4, pa[i][14:0]});
      ins(OP_MOVIW);
    end
    rd(REG_PTR1, 32'h0000_0f7f);
    wr(REG_STATUS, 32'h0000_0005);
    pc_in     <= 15'h0abc;
    w_in      <= 8'h5a;
    bsr_in    <= 5'h13;
    pclath_in <= 7'h2e;
    ev(3'b100);
    wr(REG_STATUS, 32'h0000_0002);
    wr(REG_PTR0, 32'h0000_0000);
    q_ret.push_back(15'h0abc);
    q_res.push_back({8'h5a, 5'h13, 7'h2e});
    ins(OP_RETFIE);
    rd(REG_STATUS, 32'h0000_000d);
    rd(REG_PTR0, 32'h0000_8123);
    for (int i = 0; i < 17; i++) begin
      r = 15'($urandom);
      pc_in <= r;
      if (i < 16) q_ret.push_front(r);
      ins(OP_CALL);
    end
    rd(REG_DEPTH, 32'h0000_0010);
    rd(REG_POWER_RESET_CAUSE_REG, 32'h0000_0002);
    repeat (16) ins(OP_RETURN);
    rd(REG_DEPTH, 32'h0000_0000);
    wr(REG_POWER_RESET_CAUSE_REG, 32'h0000_0004);
    q_ret.push_back(15'h0000);
    ins(OP_RETURN);
    rd(REG_POWER_RESET_CAUSE_REG, 32'h0000_0005);
    repeat (2) @(posedge ref_clk);
    chk(34'(soft_seen), 34'd1);
    chk(34'(res_seen), 34'd13);
    conclude();
  end
endmodule // test_core_status_stack_pointers
